/* File: logic/ahp_host_port.sv */
// pin-level host port driving a removable ata card in direct_ata_mode
// assumes card pins are asynchronous to clk_sys_i; user command side is on clk_sys_i
`timescale 1ns/1ns
`default_nettype none
module ahp_host_port (
	input  wire logic                        clk_sys_i,
	input  wire logic                        rst_b_i,
	// user side
	input  wire logic                        cmd_valid_i,
	input  wire ahp_pkg::ahp_cmd_s           cmd_i,
	output logic                             cmd_ready_o,
	input  wire logic                        card_reset_req_i,
	output logic [ahp_pkg::DATA_W-1:0]       rd_data_o,
	output logic                             rd_valid_o,
	input  wire logic                        rd_ready_i,
	output logic                             card_irq_o,
	output logic                             card_present_o,
	output logic                             card_dma_pending_o,
	// card pins
	output logic                             card_chip_select0_n_o,
	output logic [ahp_pkg::ADDR_W-1:0]       card_reg_addr_o,
	input  wire logic [ahp_pkg::DATA_W-1:0]  card_data_bus_i,
	output logic [ahp_pkg::DATA_W-1:0]       card_data_bus_o,
	output logic [1:0]                       card_data_bus_oe_o,
	output logic                             card_read_strobe_n_o,
	output logic                             card_write_strobe_n_o,
	output logic                             card_hw_reset_n_o,
	output logic                             card_dma_ack_n_o,
	input  wire logic                        card_interrupt_req_i,
	input  wire logic                        card_io_ready_in_i,
	input  wire logic                        card_detect_n_i,
	input  wire logic                        card_dma_request_i
);

	// ****************************************
	// pin synchronisers
	// ****************************************
	ahp_pkg::ahp_pins_s pins_raw;
	ahp_pkg::ahp_pins_s pins_meta_reg;
	ahp_pkg::ahp_pins_s pins_sync_reg;

	assign pins_raw = '{irq: card_interrupt_req_i, io_ready: card_io_ready_in_i,
		detect_n: card_detect_n_i, dma_req: card_dma_request_i, data: card_data_bus_i};

	// data is also synchronised; it is sampled late in the strobe, long after it settled
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pins_meta_reg <= ahp_pkg::PINS_RST;
			pins_sync_reg <= ahp_pkg::PINS_RST;
		end else begin
			pins_meta_reg <= pins_raw;
			pins_sync_reg <= pins_meta_reg;
		end
	end

	// ****************************************
	// status outputs
	// ****************************************
	logic irq_reg, irq_next;
	logic present_reg, present_next;
	logic dma_pend_reg, dma_pend_next;

	always_comb begin
		irq_next      = pins_sync_reg.irq;
		present_next  = !pins_sync_reg.detect_n;
		dma_pend_next = pins_sync_reg.dma_req;
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq_reg      <= 1'b0;
			present_reg  <= 1'b0;
			dma_pend_reg <= 1'b0;
		end else begin
			irq_reg      <= irq_next;
			present_reg  <= present_next;
			dma_pend_reg <= dma_pend_next;
		end
	end

	// ****************************************
	// read data fifo
	// ****************************************
	logic                       push_reg, push_next;
	logic [ahp_pkg::DATA_W-1:0] push_data_reg, push_data_next;
	logic                       fifo_in_ready;

	ahp_fifo #(
		.WIDTH (ahp_pkg::DATA_W),
		.DEPTH (ahp_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_sys_i   (clk_sys_i),
		.rst_b_i     (rst_b_i),
		.in_valid_i  (push_reg),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (push_data_reg),
		.out_valid_o (rd_valid_o),
		.out_ready_i (rd_ready_i),
		.out_data_o  (rd_data_o)
	);

	// ****************************************
	// access sequencer
	// ****************************************
	ahp_pkg::ahp_state_e              state_reg, state_next;
	logic [ahp_pkg::CNT_W-1:0]        cnt_reg, cnt_next;
	ahp_pkg::ahp_cmd_s                cmd_reg, cmd_next;
	logic                             ready_reg, ready_next;
	logic                             cs_n_reg, cs_n_next;
	logic [ahp_pkg::ADDR_W-1:0]       addr_reg, addr_next;
	logic [ahp_pkg::DATA_W-1:0]       dout_reg, dout_next;
	logic [1:0]                       oe_reg, oe_next;
	logic                             rd_n_reg, rd_n_next;
	logic                             wr_n_reg, wr_n_next;
	logic                             rst_n_reg, rst_n_next;
	logic                             ack_n_reg, ack_n_next;
	logic                             cnt_done;
	logic                             go;

	assign cnt_done = (cnt_reg == ahp_pkg::CNT_RST);

	always_comb begin
		state_next     = state_reg;
		cnt_next       = cnt_done ? cnt_reg : cnt_reg - 1'b1;
		cmd_next       = cmd_reg;
		cs_n_next      = cs_n_reg;
		addr_next      = addr_reg;
		dout_next      = dout_reg;
		oe_next        = oe_reg;
		rd_n_next      = 1'b1;
		wr_n_next      = 1'b1;
		rst_n_next     = 1'b1;
		ack_n_next     = ack_n_reg;
		push_next      = 1'b0;
		push_data_next = push_data_reg;
		go             = 1'b0;
		case (state_reg)
			ahp_pkg::ST_RESET: begin
				rst_n_next = cnt_done;
				if (cnt_done) begin
					state_next = ahp_pkg::ST_IDLE;
				end
			end
			ahp_pkg::ST_IDLE: begin
				cs_n_next  = 1'b1;
				ack_n_next = 1'b1;
				oe_next    = ahp_pkg::LANE_OFF;
				if (card_reset_req_i) begin
					state_next = ahp_pkg::ST_RESET;
					rst_n_next = 1'b0;
					cnt_next   = ahp_pkg::RESET_CYC - 1'b1;
				end else if (cmd_valid_i && ready_reg) begin
					cmd_next   = cmd_i;
					state_next = ahp_pkg::ST_SETUP;
					cnt_next   = ahp_pkg::SETUP_CYC - 1'b1;
				end
			end
			ahp_pkg::ST_SETUP: begin
				addr_next = cmd_reg.addr;
				cs_n_next = cmd_reg.dma;
				if (cmd_reg.write) begin
					// task file writes drive only the low byte lane
					dout_next = cmd_reg.block ? cmd_reg.wdata : {8'h00, cmd_reg.wdata[7:0]};
					oe_next   = cmd_reg.block ? ahp_pkg::LANE_ALL : ahp_pkg::LANE_LO;
				end
				// a read waits for fifo room, so a full fifo stalls the command side
				go = cnt_done && (cmd_reg.write || fifo_in_ready) && (!cmd_reg.dma || pins_sync_reg.dma_req);
				if (cmd_reg.dma && pins_sync_reg.dma_req) begin
					ack_n_next = 1'b0;
				end
				if (go) begin
					state_next = ahp_pkg::ST_STROBE;
					cnt_next   = ahp_pkg::STROBE_CYC - 1'b1;
					rd_n_next  = cmd_reg.write;
					wr_n_next  = !cmd_reg.write;
				end
			end
			ahp_pkg::ST_STROBE: begin
				rd_n_next = cmd_reg.write;
				wr_n_next = !cmd_reg.write;
				// card may stretch the strobe by holding io ready low
				if (cnt_done && pins_sync_reg.io_ready) begin
					state_next = ahp_pkg::ST_RECOVER;
					cnt_next   = ahp_pkg::RECOVER_CYC - 1'b1;
					rd_n_next  = 1'b1;
					wr_n_next  = 1'b1;
					if (!cmd_reg.write) begin
						push_next      = 1'b1;
						push_data_next = cmd_reg.block ? pins_sync_reg.data : {8'h00, pins_sync_reg.data[7:0]};
					end
				end
			end
			ahp_pkg::ST_RECOVER: begin
				if (cnt_done) begin
					state_next = ahp_pkg::ST_IDLE;
					cs_n_next  = 1'b1;
					ack_n_next = 1'b1;
					oe_next    = ahp_pkg::LANE_OFF;
				end
			end
			default: begin
				state_next = ahp_pkg::ST_IDLE;
			end
		endcase
		ready_next = (state_next == ahp_pkg::ST_IDLE) && !card_reset_req_i;
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_reg     <= ahp_pkg::ST_RESET;
			cnt_reg       <= ahp_pkg::RESET_CYC - 1'b1;
			cmd_reg       <= ahp_pkg::CMD_RST;
			ready_reg     <= 1'b0;
			cs_n_reg      <= 1'b1;
			addr_reg      <= ahp_pkg::ADDR_RST;
			dout_reg      <= ahp_pkg::DATA_RST;
			oe_reg        <= ahp_pkg::LANE_OFF;
			rd_n_reg      <= 1'b1;
			wr_n_reg      <= 1'b1;
			rst_n_reg     <= 1'b0;
			ack_n_reg     <= 1'b1;
			push_reg      <= 1'b0;
			push_data_reg <= ahp_pkg::DATA_RST;
		end else begin
			state_reg     <= state_next;
			cnt_reg       <= cnt_next;
			cmd_reg       <= cmd_next;
			ready_reg     <= ready_next;
			cs_n_reg      <= cs_n_next;
			addr_reg      <= addr_next;
			dout_reg      <= dout_next;
			oe_reg        <= oe_next;
			rd_n_reg      <= rd_n_next;
			wr_n_reg      <= wr_n_next;
			rst_n_reg     <= rst_n_next;
			ack_n_reg     <= ack_n_next;
			push_reg      <= push_next;
			push_data_reg <= push_data_next;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign cmd_ready_o           = ready_reg;
	assign card_irq_o            = irq_reg;
	assign card_present_o        = present_reg;
	assign card_dma_pending_o    = dma_pend_reg;
	assign card_chip_select0_n_o = cs_n_reg;
	assign card_reg_addr_o       = addr_reg;
	assign card_data_bus_o       = dout_reg;
	assign card_data_bus_oe_o    = oe_reg;
	assign card_read_strobe_n_o  = rd_n_reg;
	assign card_write_strobe_n_o = wr_n_reg;
	assign card_hw_reset_n_o     = rst_n_reg;
	assign card_dma_ack_n_o      = ack_n_reg;
endmodule
`default_nettype wire

/* File: logic/ahp_pkg.sv */
// package of constants and carrier types for the ata card host pin port
// assumes a single 100 MHz clock and no software-visible registers
package ahp_pkg;

	// ****************************************
	// widths
	// ****************************************
	localparam int DATA_W     = 16;
	localparam int ADDR_W     = 3;
	localparam int FIFO_DEPTH = 32;
	localparam int CNT_W      = 12;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int SETUP_NS      = 30;
	localparam int STROBE_NS     = 80;
	localparam int RECOVER_NS    = 30;
	localparam int RESET_NS      = 25000;

	// least times round up to whole cycles
	localparam logic [CNT_W-1:0] SETUP_CYC   = CNT_W'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] STROBE_CYC  = CNT_W'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] RECOVER_CYC = CNT_W'((RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] RESET_CYC   = CNT_W'((RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ****************************************
	// reset values and data lane enables
	// ****************************************
	localparam logic [CNT_W-1:0]  CNT_RST  = 12'h000;
	localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
	localparam logic [ADDR_W-1:0] ADDR_RST = 3'h0;
	localparam logic [1:0]        LANE_OFF = 2'h0;
	localparam logic [1:0]        LANE_LO  = 2'h1;
	localparam logic [1:0]        LANE_ALL = 2'h3;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [2:0] {
		ST_RESET,
		ST_IDLE,
		ST_SETUP,
		ST_STROBE,
		ST_RECOVER
	} ahp_state_e;

	typedef struct packed {
		logic              write;
		logic              block;
		logic              dma;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} ahp_cmd_s;

	typedef struct packed {
		logic              irq;
		logic              io_ready;
		logic              detect_n;
		logic              dma_req;
		logic [DATA_W-1:0] data;
	} ahp_pins_s;

	localparam ahp_cmd_s  CMD_RST  = '0;
	localparam ahp_pins_s PINS_RST = '0;

endpackage

/* File: logic/ahp_fifo.sv */
// word fifo with a registered output stage
// assumes both sides on one clock; capacity is DEPTH plus the output word
`timescale 1ns/1ns
`default_nettype none
module ahp_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	input  wire logic             clk_sys_i,
	input  wire logic             rst_b_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg, wr_ptr_next;
	logic [AW-1:0]    rd_ptr_reg, rd_ptr_next;
	logic [AW:0]      cnt_reg, cnt_next;
	logic             valid_reg, valid_next;
	logic [WIDTH-1:0] data_reg, data_next;
	logic             push;
	logic             load;
	logic             pop;

	always_comb begin
		in_ready_o  = (cnt_reg != (AW+1)'(DEPTH));
		push        = in_valid_i && in_ready_o;
		load        = !valid_reg || out_ready_i;
		pop         = load && (cnt_reg != '0);
		wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
		rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
		cnt_next    = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		valid_next  = load ? (cnt_reg != '0) : valid_reg;
		data_next   = pop ? mem[rd_ptr_reg] : data_reg;
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			cnt_reg    <= '0;
			valid_reg  <= 1'b0;
			data_reg   <= '0;
		end else begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			cnt_reg    <= cnt_next;
			valid_reg  <= valid_next;
			data_reg   <= data_next;
		end
	end

	// storage is not reset; only the pointers give it meaning
	always_ff @(posedge clk_sys_i) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data_i;
		end
	end

	assign out_valid_o = valid_reg;
	assign out_data_o  = data_reg;
endmodule
`default_nettype wire

/* File: logic/ahp_pkg_unused_guard.sv */
// empty unit: holds no logic of its own
// assumes nothing of its surroundings
`default_nettype none
`default_nettype wire

/* File: tb/ahp_card_model.sv */
// behavioural card on the host port pins: task file, one block word, slow ready
// assumes the bench resolves the shared data bus with its pull-downs
`timescale 1ns/1ns
`default_nettype none
module ahp_card_model (
	input  wire logic        cs0_n_i,
	input  wire logic        ack_n_i,
	input  wire logic        rd_n_i,
	input  wire logic        wr_n_i,
	input  wire logic [2:0]  addr_i,
	input  wire logic [15:0] bus_i,
	input  var  int          stall_i,
	output logic [15:0]      drv_o,
	output logic             drv_en_o,
	output logic             io_ready_o
);
	logic [7:0]  tf [8];
	logic [15:0] blk_word = 16'h0000;
	logic        sel;
	initial io_ready_o = 1'b1;
	assign sel = !cs0_n_i || !ack_n_i;
	assign drv_en_o = sel && !rd_n_i;
	// junk upper byte on task file reads, so a missing zero-extension shows
	assign drv_o = (addr_i == 3'h0) ? blk_word : {~tf[addr_i], tf[addr_i]};
	always @(posedge wr_n_i) begin
		if (sel && addr_i == 3'h0) blk_word <= bus_i;
		else if (sel) tf[addr_i] <= bus_i[7:0];
	end
	// each block read advances the word, so fifo order is visible
	always @(posedge rd_n_i) begin
		if (sel && addr_i == 3'h0) blk_word <= blk_word + 16'h0001;
	end
	always @(negedge rd_n_i or negedge wr_n_i) begin
		if (stall_i > 0) begin
			io_ready_o = 1'b0;
			// off the clock edge, so the release never races the synchroniser
			#(stall_i * 10 + 1);
			io_ready_o = 1'b1;
		end
	end
endmodule
`default_nettype wire

/* File: tb/ahp_host_port_sva.sv */
// checker for the card pin side of ahp_host_port
// assumes it is bound onto the ports of ahp_host_port
`timescale 1ns/1ns
`default_nettype none
module ahp_host_port_sva (
	input wire logic       clk_sys_i,
	input wire logic       rst_b_i,
	input wire logic       cmd_ready_o,
	input wire logic       card_irq_o,
	input wire logic       card_present_o,
	input wire logic       card_dma_pending_o,
	input wire logic       card_chip_select0_n_o,
	input wire logic [1:0] card_data_bus_oe_o,
	input wire logic       card_read_strobe_n_o,
	input wire logic       card_write_strobe_n_o,
	input wire logic       card_hw_reset_n_o,
	input wire logic       card_dma_ack_n_o,
	input wire logic       card_interrupt_req_i,
	input wire logic       card_detect_n_i,
	input wire logic       card_dma_request_i
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);
	wire rd = !card_read_strobe_n_o;
	wire wr = !card_write_strobe_n_o;
	// status checks wait until the synchronisers hold post-reset pin values
	logic [2:0] up_cnt;
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) up_cnt <= 3'h0;
		else if (up_cnt != 3'h7) up_cnt <= up_cnt + 3'h1;
	end
	property p_excl; !(rd && wr); endproperty
	a_excl: assert property (p_excl) else $error("strobes overlap");
	property p_rst_idle; !card_hw_reset_n_o |-> !rd && !wr && !cmd_ready_o; endproperty
	a_rst_idle: assert property (p_rst_idle) else $error("activity in card reset");
	property p_sel; (rd || wr) |-> (!card_chip_select0_n_o ^ !card_dma_ack_n_o); endproperty
	a_sel: assert property (p_sel) else $error("strobe without one select");
	property p_rd_len; $fell(card_read_strobe_n_o) |-> !card_read_strobe_n_o [*8]; endproperty
	a_rd_len: assert property (p_rd_len) else $error("read strobe short");
	property p_wr_len; $fell(card_write_strobe_n_o) |-> !card_write_strobe_n_o [*8]; endproperty
	a_wr_len: assert property (p_wr_len) else $error("write strobe short");
	property p_lanes; (rd || wr) |-> ((card_data_bus_oe_o == 2'h0) == rd); endproperty
	a_lanes: assert property (p_lanes) else $error("data lanes wrong");
	property p_present; up_cnt == 3'h7 |-> card_present_o == !$past(card_detect_n_i, 3); endproperty
	a_present: assert property (p_present) else $error("presence wrong");
	property p_irq; up_cnt == 3'h7 |-> card_irq_o == $past(card_interrupt_req_i, 3); endproperty
	a_irq: assert property (p_irq) else $error("interrupt wrong");
	property p_dma; up_cnt == 3'h7 |-> card_dma_pending_o == $past(card_dma_request_i, 3); endproperty
	a_dma: assert property (p_dma) else $error("dma request wrong");
endmodule
`default_nettype wire

/* File: tb/test_ahp_host_port.sv */
// self-checking bench for ahp_host_port with a card model on its pins
// assumes the 100 MHz clock and the package fifo depth of 32 plus one
`timescale 1ns/1ns
`default_nettype none
module test_ahp_host_port;
	logic              clk_sys_i, rst_b_i = 1'b0, cmd_valid = 1'b0, rd_ready = 1'b0, rst_req = 1'b0;
	logic              irq = 1'b0, det_n = 1'b0, dma_rq = 1'b0;
	ahp_pkg::ahp_cmd_s cmd = '0;
	logic [15:0]       rd_data, bus_o, bus_w, m_drv;
	logic [1:0]        oe;
	logic [2:0]        addr;
	logic              rd_valid, ready, c_irq, c_pres, c_dma, cs_n, rd_n, wr_n, hrst_n, ack_n, m_en, io_rdy;
	int                stall = 0, n_mismatch = 0, cmp_count = 0, ack_lo = 0, cs_lo = 0, n;
	logic [15:0]       blk = 16'hC3A5;
	// pull-downs on the data pins win where nobody drives
	assign bus_w[7:0] = oe[0] ? bus_o[7:0] : m_en ? m_drv[7:0] : 8'h00;
	assign bus_w[15:8] = oe[1] ? bus_o[15:8] : m_en ? m_drv[15:8] : 8'h00;
	ahp_host_port DUT (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .cmd_valid_i(cmd_valid), .cmd_i(cmd),
		.cmd_ready_o(ready), .card_reset_req_i(rst_req), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
		.rd_ready_i(rd_ready), .card_irq_o(c_irq), .card_present_o(c_pres), .card_dma_pending_o(c_dma),
		.card_chip_select0_n_o(cs_n), .card_reg_addr_o(addr), .card_data_bus_i(bus_w), .card_data_bus_o(bus_o),
		.card_data_bus_oe_o(oe), .card_read_strobe_n_o(rd_n), .card_write_strobe_n_o(wr_n),
		.card_hw_reset_n_o(hrst_n), .card_dma_ack_n_o(ack_n), .card_interrupt_req_i(irq),
		.card_io_ready_in_i(io_rdy), .card_detect_n_i(det_n), .card_dma_request_i(dma_rq));
	ahp_card_model u_card (.cs0_n_i(cs_n), .ack_n_i(ack_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .addr_i(addr),
		.bus_i(bus_w), .stall_i(stall), .drv_o(m_drv), .drv_en_o(m_en), .io_ready_o(io_rdy));
	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		if (!ack_n) ack_lo++;
		if (!cs_n) cs_lo++;
	end
	// ****************************************
	// shared tasks
	// ****************************************
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic finish_test();
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic wait_ready(input int lim);
		for (int i = 0; i < lim && ready !== 1'b1; i++) @(posedge clk_sys_i);
		if (ready !== 1'b1) begin
			n_mismatch++;
			finish_test();
		end
	endtask
	task automatic do_cmd(input logic w, b, d, input logic [2:0] a, input logic [15:0] wd);
		wait_ready(3000);
		cmd_valid <= 1'b1;
		cmd <= '{write: w, block: b, dma: d, addr: a, wdata: wd};
		@(posedge clk_sys_i);
		cmd_valid <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	task automatic pop(input logic [15:0] exp);
		int i = 0;
		rd_ready <= 1'b1;
		do begin
			@(posedge clk_sys_i);
			i++;
		end while (rd_valid !== 1'b1 && i < 200);
		if (rd_valid !== 1'b1) begin
			n_mismatch++;
			finish_test();
		end
		chk("read data", exp, rd_data);
	endtask
	task automatic wr_len(output int cnt);
		cnt = 0;
		for (int i = 0; i < 50 && wr_n !== 1'b0; i++) @(posedge clk_sys_i);
		while (wr_n === 1'b0 && cnt < 200) begin
			@(posedge clk_sys_i);
			cnt++;
		end
		// a strobe that never came or never ended is a hang
		if (cnt == 0 || cnt >= 200) begin
			n_mismatch++;
			finish_test();
		end
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset();
		repeat (2400) @(posedge clk_sys_i);
		chk("card reset held", 16'h0000, hrst_n);
		wait_ready(300);
		chk("card reset released", 16'h0001, hrst_n);
	endtask
	task automatic t_taskfile();
		for (int a = 1; a < 8; a++) do_cmd(1'b1, 1'b0, 1'b0, 3'(a), {8'hEE, 8'(8'h30 + a)});
		for (int a = 1; a < 8; a++) begin
			do_cmd(1'b0, 1'b0, 1'b0, 3'(a), 16'h0000);
			pop({8'h00, 8'(8'h30 + a)});
		end
	endtask
	task automatic t_block();
		fork do_cmd(1'b1, 1'b1, 1'b0, 3'h0, blk); wr_len(n); join
		chk("write strobe", 16'(ahp_pkg::STROBE_CYC), 16'(n));
		stall = 20;
		fork do_cmd(1'b1, 1'b1, 1'b0, 3'h0, blk); wr_len(n); join
		chk("slow strobe stretched", 16'h0001, 16'(n > 20));
		do_cmd(1'b0, 1'b1, 1'b0, 3'h0, 16'h0000);
		pop(blk);
		stall = 0;
		blk++;
	endtask
	task automatic t_status();
		irq <= 1'b1;
		det_n <= 1'b1;
		dma_rq <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		chk("irq", 16'h0001, c_irq);
		chk("present", 16'h0000, c_pres);
		chk("dma pending", 16'h0001, c_dma);
		irq <= 1'b0;
		det_n <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		chk("irq", 16'h0000, c_irq);
		chk("present", 16'h0001, c_pres);
	endtask
	task automatic t_dma();
		int a0 = ack_lo;
		int c0 = cs_lo;
		do_cmd(1'b0, 1'b1, 1'b1, 3'h0, 16'h0000);
		pop(blk);
		blk++;
		chk("dma ack seen", 16'h0001, 16'(ack_lo > a0));
		chk("select idle in dma", 16'h0001, 16'(cs_lo == c0));
		dma_rq <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		chk("dma pending", 16'h0000, c_dma);
	endtask
	task automatic t_fill();
		rd_ready <= 1'b0;
		for (int i = 0; i < 34; i++) do_cmd(1'b0, 1'b1, 1'b0, 3'h0, 16'h0000);
		repeat (40) @(posedge clk_sys_i);
		chk("read held while full", 16'h0001, rd_n);
		chk("busy while full", 16'h0000, ready);
		for (int i = 0; i < 34; i++) pop(blk + 16'(i));
		blk = blk + 16'h0022;
		rd_ready <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		chk("fifo empty", 16'h0000, rd_valid);
	endtask
	task automatic t_card_reset();
		wait_ready(300);
		rst_req <= 1'b1;
		@(posedge clk_sys_i);
		rst_req <= 1'b0;
		repeat (10) @(posedge clk_sys_i);
		chk("card reset asserted", 16'h0000, hrst_n);
		chk("busy in card reset", 16'h0000, ready);
		wait_ready(3000);
		chk("card reset released", 16'h0001, hrst_n);
	endtask
	initial begin
		repeat (10) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		t_reset();
		t_taskfile();
		t_block();
		t_status();
		t_dma();
		t_fill();
		t_card_reset();
		finish_test();
	end
endmodule
bind ahp_host_port ahp_host_port_sva u_sva (.clk_sys_i, .rst_b_i, .cmd_ready_o, .card_irq_o, .card_present_o,
	.card_dma_pending_o, .card_chip_select0_n_o, .card_data_bus_oe_o, .card_read_strobe_n_o,
	.card_write_strobe_n_o, .card_hw_reset_n_o, .card_dma_ack_n_o, .card_interrupt_req_i, .card_detect_n_i,
	.card_dma_request_i);
`default_nettype wire
